// file: design/est_pkg.sv
// Shared constants and types for the eight/sixteen-bit timer block
package est_pkg;

  // ==========================================================
  // Bus geometry
  localparam int unsigned ADR_W  = 8;
  localparam int unsigned DAT_W  = 32;
  localparam int unsigned SEL_W  = 4;

  // ==========================================================
  // Register byte offsets
  localparam logic [ADR_W-1:0] OFF_TIMER_CONTROL     = 8'h00;
  localparam logic [ADR_W-1:0] OFF_COUNT_LOW_BYTE    = 8'h04;
  localparam logic [ADR_W-1:0] OFF_COUNT_HIGH_BUFFER = 8'h08;
  localparam logic [ADR_W-1:0] OFF_STATUS            = 8'h0c;

  // Status register field positions
  localparam int unsigned STAT_FLAG_BIT = 0;  // overflow_flag, write 1 clears
  localparam int unsigned STAT_IEN_BIT  = 1;  // overflow_irq_enable

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] CTRL_RESET      = 8'hff;
  localparam logic [7:0] HIGH_BUF_RESET  = 8'h00;
  localparam logic [7:0] COUNT_RESET     = 8'h00;
  localparam logic [7:0] BYTE_ONES       = 8'hff;
  localparam logic [1:0] INHIBIT_CYCLES  = 2'h2;
  localparam logic [1:0] INHIBIT_NONE    = 2'h0;
  localparam logic [1:0] INHIBIT_STEP    = 2'h1;
  localparam logic [7:0] PRESCALE_RESET  = 8'h00;
  localparam logic [7:0] BYTE_STEP       = 8'h01;
  localparam logic [DAT_W-1:0] DAT_ZERO  = 32'h0000_0000;

  // ==========================================================
  // Types
  typedef struct packed {
    logic       runEnable;        // bit 7
    logic       widthSelect;      // bit 6, 1 = 8-bit
    logic       sourceSelect;     // bit 5, 1 = external pin
    logic       edgeSelect;       // bit 4, 1 = falling edge
    logic       prescalerBypass;  // bit 3, 1 = no prescaler
    logic [2:0] prescaleRatio;    // bits 2:0
  } est_ctrl_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } est_wb_req_t;

endpackage : est_pkg

// file: design/est_prescaler.sv
// Eight-bit prescaler with power-of-two tap selection
`timescale 1ns/10ps
module est_prescaler
  import est_pkg::*;
(
  input  wire logic       clk,       // Instruction clock
  input  wire logic       rst_n,     // Async reset, active low
  input  wire logic       clear,     // Clear count
  input  wire logic       tickIn,    // Source tick
  input  wire logic [2:0] ratio,     // Ratio code
  output logic            tickOut    // Divided tick
);

  typedef struct packed {
    logic [7:0] count;
  } est_pre_state_t;

  est_pre_state_t stateReg;
  est_pre_state_t stateNext;
  logic [7:0]     tapMask;

  // ==========================================================
  // Tap mask: bits 0..ratio take part in the divide
  for (genvar i = 0; i < 8; i++) begin : g_mask
    assign tapMask[i] = (i <= int'(ratio));
  end

  assign tickOut = tickIn && ((stateReg.count | ~tapMask) == BYTE_ONES);

  // ==========================================================
  // Next state
  always_comb begin
    stateNext = stateReg;
    if (clear) begin
      stateNext.count = PRESCALE_RESET;
    end else if (tickIn) begin
      stateNext.count = stateReg.count + BYTE_STEP;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg <= '0;
    end else begin
      stateReg <= stateNext;
    end
  end

endmodule : est_prescaler

// file: design/est_timer.sv
// Eight/sixteen-bit timer-counter with classic Wishbone slave
`timescale 1ns/10ps

module est_timer
  import est_pkg::*;
(
  input  wire logic             clk,              // Instruction clock
  input  wire logic             rst_n,            // Async reset, active low
  input  wire est_wb_req_t      wbReq,            // Wishbone request group
  output logic                  wbAck,            // Wishbone ack
  output logic [DAT_W-1:0]      wbDatOut,         // Wishbone read data
  input  wire logic             externalCountPin, // External count input
  input  wire logic             sleepMode,        // Processor asleep
  output logic                  overflowIrq       // Gated overflow request
);

  // ==========================================================
  // State record
  typedef struct packed {
    est_ctrl_t        ctrl;
    logic [7:0]       cntLo;
    logic [7:0]       cntHi;
    logic [7:0]       hiBuf;
    logic             flag;
    logic             irqEn;
    logic [1:0]       inhibit;
    logic [2:0]       pinSync;
    logic             ack;
    logic [DAT_W-1:0] datOut;
    logic             irq;
  } est_state_t;

  est_state_t stateReg;
  est_state_t stateNext;

  logic busReq;     // New access this cycle
  logic wrStrobe;   // Write accepted this cycle
  logic rdStrobe;   // Read accepted this cycle
  logic loWr;       // Low-byte write
  logic loRd;       // Low-byte read
  logic hiWr;       // High-buffer write
  logic ctrlWr;     // Control write
  logic statWr;     // Status write
  logic pinRise;    // Synchronised rising edge
  logic pinFall;    // Synchronised falling edge
  logic srcTick;    // Selected source tick
  logic preTick;    // Prescaler output
  logic incTick;    // Tick after assignment
  logic cntStep;    // Counter advances this cycle
  logic wrap8;      // Low byte at all ones
  logic wrap16;     // Both bytes at all ones
  logic flagSet;    // Overflow event
  logic flagClr;    // Software clear of flag

  // ==========================================================
  // Bus decode: one access per request, ack a cycle later
  assign busReq   = wbReq.cyc && wbReq.stb && !stateReg.ack;
  assign wrStrobe = busReq && wbReq.we && wbReq.sel[0];
  assign rdStrobe = busReq && !wbReq.we;
  assign ctrlWr   = wrStrobe && (wbReq.adr == OFF_TIMER_CONTROL);
  assign loWr     = wrStrobe && (wbReq.adr == OFF_COUNT_LOW_BYTE);
  assign hiWr     = wrStrobe && (wbReq.adr == OFF_COUNT_HIGH_BUFFER);
  assign statWr   = wrStrobe && (wbReq.adr == OFF_STATUS);
  assign loRd     = rdStrobe && (wbReq.adr == OFF_COUNT_LOW_BYTE);
  assign flagClr  = statWr && wbReq.dat[STAT_FLAG_BIT];

  // ==========================================================
  // Pin edge detection on synchronised stages only
  // edges from second and third stages
  assign pinRise = stateReg.pinSync[1] && !stateReg.pinSync[2];
  assign pinFall = !stateReg.pinSync[1] && stateReg.pinSync[2];

  // Source selection
  // cycle or pin edge
  always_comb begin
    if (stateReg.ctrl.sourceSelect) begin
      srcTick = stateReg.ctrl.edgeSelect ? pinFall : pinRise;
    end else begin
      srcTick = 1'b1;
    end
  end

  // Prescaler sees ticks only while running and awake
  est_prescaler u_prescaler (
    .clk     (clk),
    .rst_n   (rst_n),
    .clear   (loWr),
    .tickIn  (srcTick && stateReg.ctrl.runEnable && !sleepMode),
    .ratio   (stateReg.ctrl.prescaleRatio),
    .tickOut (preTick)
  );

  assign incTick = stateReg.ctrl.prescalerBypass ? srcTick : preTick;

  // Advance gating
  // run gate
  assign cntStep = incTick && stateReg.ctrl.runEnable && !sleepMode
                   && (stateReg.inhibit == INHIBIT_NONE);

  assign wrap8   = (stateReg.cntLo == BYTE_ONES);
  assign wrap16  = wrap8 && (stateReg.cntHi == BYTE_ONES);
  assign flagSet = cntStep && !loWr
                   && (stateReg.ctrl.widthSelect ? wrap8 : wrap16);

  // ==========================================================
  // Next-state logic
  always_comb begin
    stateNext = stateReg;

    // Synchroniser shift; first stage feeds second only
    stateNext.pinSync = {stateReg.pinSync[1:0], externalCountPin};

    // Inhibit countdown
    if (stateReg.inhibit != INHIBIT_NONE) begin
      stateNext.inhibit = stateReg.inhibit - INHIBIT_STEP;
    end

    // Counter update, write beats increment
    if (loWr) begin
      stateNext.cntLo = wbReq.dat[7:0];
      stateNext.inhibit = INHIBIT_CYCLES;
      if (!stateReg.ctrl.widthSelect) begin
        stateNext.cntHi = stateReg.hiBuf;
      end
    end else if (cntStep) begin
      stateNext.cntLo = stateReg.cntLo + BYTE_STEP;
      // carry into high only in 16-bit
      if (!stateReg.ctrl.widthSelect && wrap8) begin
        stateNext.cntHi = stateReg.cntHi + BYTE_STEP;
      end
    end

    // high writes land in buffer only
    if (hiWr) begin
      stateNext.hiBuf = wbReq.dat[7:0];
    end else if (loRd && !stateReg.ctrl.widthSelect) begin
      stateNext.hiBuf = stateReg.cntHi;
    end

    if (ctrlWr) begin
      stateNext.ctrl = est_ctrl_t'(wbReq.dat[7:0]);
    end

    // sticky flag, set wins over clear
    stateNext.flag = (stateReg.flag && !flagClr) || flagSet;
    if (statWr) begin
      stateNext.irqEn = wbReq.dat[STAT_IEN_BIT];
    end
    stateNext.irq = stateNext.flag && stateNext.irqEn;

    // Bus answer, unmapped reads give zero
    stateNext.ack = busReq;
    stateNext.datOut = DAT_ZERO;
    if (rdStrobe) begin
      case (wbReq.adr)
        OFF_TIMER_CONTROL: begin
          stateNext.datOut[7:0] = stateReg.ctrl;
        end
        OFF_COUNT_LOW_BYTE: begin
          stateNext.datOut[7:0] = stateReg.cntLo;
        end
        OFF_COUNT_HIGH_BUFFER: begin
          stateNext.datOut[7:0] = stateReg.hiBuf;
        end
        OFF_STATUS: begin
          stateNext.datOut[STAT_FLAG_BIT] = stateReg.flag;
          stateNext.datOut[STAT_IEN_BIT]  = stateReg.irqEn;
        end
        default: begin
          stateNext.datOut = DAT_ZERO;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg         <= '0;
      stateReg.ctrl    <= est_ctrl_t'(CTRL_RESET);
      stateReg.cntLo   <= COUNT_RESET;
      stateReg.cntHi   <= COUNT_RESET;
      stateReg.hiBuf   <= HIGH_BUF_RESET;
      stateReg.inhibit <= INHIBIT_NONE;
    end else begin
      stateReg <= stateNext;
    end
  end

  // Outputs straight from flops
  assign wbAck       = stateReg.ack;
  assign wbDatOut    = stateReg.datOut;
  assign overflowIrq = stateReg.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  AST_RESET_CTRL: assert property (
    disable iff (1'b0) $rose(rst_n) |-> stateReg.ctrl == CTRL_RESET)
    else $error("control not all ones after reset");

  AST_FREEZE: assert property (
    (!stateReg.ctrl.runEnable && !loWr) |=> $stable(stateReg.cntLo))
    else $error("count moved while stopped");

  AST_HIGH_HELD_8BIT: assert property (
    (stateReg.ctrl.widthSelect && !loWr && !ctrlWr)
      |=> $stable(stateReg.cntHi))
    else $error("high byte changed in 8-bit mode");

  AST_WRITE_INHIBIT: assert property (
    loWr |=> (!cntStep)[*2])
    else $error("count advanced inside write hold");

  AST_TIMER_STEP: assert property (
    (!stateReg.ctrl.sourceSelect && stateReg.ctrl.prescalerBypass
     && stateReg.ctrl.runEnable && !sleepMode && !loWr
     && stateReg.inhibit == INHIBIT_NONE)
      |=> stateReg.cntLo == $past(stateReg.cntLo) + BYTE_STEP)
    else $error("timer mode did not step");

  AST_WRAP8_FLAG: assert property (
    (cntStep && !loWr && stateReg.ctrl.widthSelect && wrap8)
      |=> stateReg.flag && stateReg.cntLo == COUNT_RESET)
    else $error("8-bit wrap did not set flag");

  AST_FLAG_STICKY: assert property (
    (stateReg.flag && !flagClr) |=> stateReg.flag)
    else $error("overflow flag dropped by itself");

  AST_IRQ_GATED: assert property (
    overflowIrq |-> (stateReg.flag && stateReg.irqEn))
    else $error("request without flag and enable");

  AST_SLEEP_HALT: assert property (
    sleepMode |-> !cntStep)
    else $error("count advanced in sleep");

  AST_COHERENT_READ: assert property (
    (loRd && !hiWr && !stateReg.ctrl.widthSelect)
      |=> stateReg.hiBuf == $past(stateReg.cntHi))
    else $error("low read did not snapshot high byte");

  AST_HIGH_LOAD: assert property (
    (loWr && !stateReg.ctrl.widthSelect)
      |=> stateReg.cntHi == $past(stateReg.hiBuf))
    else $error("low write did not load high byte");

  AST_ACK_ONE: assert property (
    wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");

  AST_ACK_LATENCY: assert property (
    busReq |=> wbAck)
    else $error("access not answered one cycle later");

  AST_DATA_IDLE: assert property (
    !wbAck |-> wbDatOut == DAT_ZERO)
    else $error("read data not zero outside ack");

  AST_CTRL_WRITE: assert property (
    ctrlWr |=> stateReg.ctrl == $past(wbReq.dat[7:0]))
    else $error("control write not stored");

  AST_INHIBIT_ARMED: assert property (
    loWr |=> stateReg.inhibit == INHIBIT_CYCLES)
    else $error("low write did not arm the hold");

  AST_PIN_ONLY: assert property (
    (stateReg.ctrl.sourceSelect && !pinRise && !pinFall)
      |-> !cntStep)
    else $error("counter mode stepped without a pin edge");

  AST_EDGE_FALLING: assert property (
    (stateReg.ctrl.sourceSelect && stateReg.ctrl.edgeSelect && pinRise)
      |-> !cntStep)
    else $error("rising pin edge counted in falling mode");

  AST_EDGE_RISING: assert property (
    (stateReg.ctrl.sourceSelect && !stateReg.ctrl.edgeSelect && pinFall)
      |-> !cntStep)
    else $error("falling pin edge counted in rising mode");

  AST_WRAP16_FLAG: assert property (
    (cntStep && !loWr && !stateReg.ctrl.widthSelect && wrap16)
      |=> stateReg.flag && stateReg.cntLo == COUNT_RESET
          && stateReg.cntHi == COUNT_RESET)
    else $error("16-bit wrap did not set flag");

  AST_NO_STRAY_FLAG: assert property (
    (!stateReg.flag && !flagSet) |=> !stateReg.flag)
    else $error("overflow flag set without a wrap");

  AST_FLAG_CLEAR: assert property (
    (flagClr && !flagSet) |=> !stateReg.flag)
    else $error("software clear did not drop the flag");

  AST_SET_WINS: assert property (
    flagSet |=> stateReg.flag)
    else $error("wrap lost against a clear");

  AST_BUF_PLAIN_8BIT: assert property (
    (loRd && stateReg.ctrl.widthSelect) |=> $stable(stateReg.hiBuf))
    else $error("low read touched buffer in 8-bit mode");

  COV_WRAP16: cover property (
    cntStep && !stateReg.ctrl.widthSelect && wrap16);
  COV_PIN_FALL: cover property (
    stateReg.ctrl.sourceSelect && stateReg.ctrl.edgeSelect && cntStep);
  COV_PRESCALED: cover property (
    !stateReg.ctrl.prescalerBypass && cntStep);
  COV_SET_CLEAR: cover property (flagSet && flagClr);
  COV_SPLIT_READ: cover property (loRd && !stateReg.ctrl.widthSelect);

endmodule : est_timer

// file: bench/est_pin_src.sv
// Behavioural source driving the external count pin in bursts
`timescale 1ns/10ps
module est_pin_src
  import est_pkg::*;
(
  input  wire logic       clk,        // Instruction clock
  input  wire logic       rst_n,      // Async reset, active low
  input  wire logic       startReq,   // Begin a burst
  input  wire logic [3:0] numToggles, // Level changes in burst
  output logic            pinOut,     // External count pin
  output logic            busy        // Burst in progress
);
  logic [3:0] leftReg;
  logic [1:0] holdReg;

  // ==========================================================
  // Burst engine
  // levels held three cycles
  // Shorter levels could slip past the input synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      leftReg <= 4'h0;
      holdReg <= 2'h0;
      pinOut  <= 1'b0;
    end else if (startReq && leftReg == 4'h0) begin
      leftReg <= numToggles;
      holdReg <= 2'h0;
    end else if (leftReg != 4'h0) begin
      if (holdReg == 2'h2) begin
        pinOut  <= ~pinOut;
        leftReg <= leftReg - 4'h1;
        holdReg <= 2'h0;
      end else begin
        holdReg <= holdReg + 2'h1;
      end
    end
  end

  // Busy while toggles remain
  assign busy = (leftReg != 4'h0);
endmodule : est_pin_src

// file: bench/eight_sixteen_bit_timer_tb.sv
// Self-checking bench for the eight/sixteen-bit timer
`timescale 1ns/10ps
module eight_sixteen_bit_timer_tb
  import est_pkg::*;
;
  logic             clk;
  logic             rst_n;
  est_wb_req_t      wbReq;
  logic             wbAck;
  logic [DAT_W-1:0] wbDatOut;
  logic             pin;
  logic             sleepMode;
  logic             overflowIrq;
  logic             startReq;
  logic [3:0]       numToggles;
  logic             busy;
  int               num_errors;
  int               check_count;
  int               cycles;

  est_timer u_est_timer (.clk(clk), .rst_n(rst_n), .wbReq(wbReq),
    .wbAck(wbAck), .wbDatOut(wbDatOut), .externalCountPin(pin),
    .sleepMode(sleepMode), .overflowIrq(overflowIrq));
  est_pin_src u_est_pin_src (.clk(clk), .rst_n(rst_n),
    .startReq(startReq), .numToggles(numToggles), .pinOut(pin),
    .busy(busy));

  // ==========================================================
  // Clock and watchdog; ceiling well above the ~2600 cycles used
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ==========================================================
  // Common tasks
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Classic cycle: hold until ack is sampled high, take data, release
  task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] adr,
                         input logic [7:0] dat, output logic [7:0] rdData);
    @(posedge clk);
    wbReq <= '{cyc:1'b1, stb:1'b1, we:we, adr:adr, sel:4'hf,
               dat:{24'h0, dat}};
    // No local limit: only the watchdog ends a hung cycle
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    rdData = wbDatOut[7:0];
    wbReq <= '0;
  endtask : wb_xfer

  task automatic wr(input logic [ADR_W-1:0] adr, input logic [7:0] dat);
    logic [7:0] d;
    wb_xfer(1'b1, adr, dat, d);
  endtask : wr

  task automatic rd(input logic [ADR_W-1:0] adr, output logic [7:0] v);
    wb_xfer(1'b0, adr, 8'h00, v);
  endtask : rd

  // Burst of level changes, then let the synchroniser settle
  task automatic pulses(input logic [3:0] n);
    numToggles <= n;
    startReq   <= 1'b1;
    @(posedge clk);
    startReq <= 1'b0;
    // A stuck burst is left to the watchdog
    do begin
      @(posedge clk);
    end while (busy === 1'b1);
    repeat (5) @(posedge clk);
  endtask : pulses

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] v;
    rd(OFF_TIMER_CONTROL, v);     check("ctrl", v, 8'hff);
    rd(OFF_COUNT_HIGH_BUFFER, v); check("hbuf", v, 8'h00);
    rd(OFF_STATUS, v);            check("stat", v, 8'h00);
    wr(8'h10, 8'h5a);
    rd(8'h10, v);                 check("unmap", v, 8'h00);
    rd(OFF_TIMER_CONTROL, v);     check("ctrl2", v, 8'hff);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_timer8();
    logic [7:0] v;
    logic [7:0] w;
    wr(OFF_TIMER_CONTROL, 8'hc8);
    wr(OFF_STATUS, 8'h03);
    wr(OFF_COUNT_LOW_BYTE, 8'hfe);
    rd(OFF_COUNT_LOW_BYTE, v);    check("inhibit", v, 8'hfe);
    rd(OFF_COUNT_LOW_BYTE, v);    check("step", v, 8'h01);
    check("irq", {7'h0, overflowIrq}, 8'h01);
    rd(OFF_STATUS, v);            check("flag8", v, 8'h03);
    wr(OFF_STATUS, 8'h01);
    rd(OFF_STATUS, v);            check("clear", v, 8'h00);
    check("irqoff", {7'h0, overflowIrq}, 8'h00);
    wr(OFF_TIMER_CONTROL, 8'h48);
    rd(OFF_COUNT_LOW_BYTE, v);
    rd(OFF_COUNT_LOW_BYTE, w);    check("frozen", w, v);
    $display("t_timer8 done");
  endtask : t_timer8

  // Low wrap carries high into 13h without flag, then full wrap sets it
  task automatic t_width16();
    logic [7:0] v;
    logic [7:0] hiIn [2];
    logic [7:0] hiExp [2];
    hiIn  = '{8'h12, 8'hff};
    hiExp = '{8'h13, 8'h00};
    wr(OFF_TIMER_CONTROL, 8'h88);
    for (int i = 0; i < 2; i++) begin
      wr(OFF_STATUS, 8'h01);
      wr(OFF_COUNT_HIGH_BUFFER, hiIn[i]);
      wr(OFF_COUNT_LOW_BYTE, 8'hfe);
      rd(OFF_COUNT_LOW_BYTE, v);    check("lo16", v, 8'hfe);
      rd(OFF_COUNT_LOW_BYTE, v);    check("lo16b", v, 8'h01);
      rd(OFF_COUNT_HIGH_BUFFER, v); check("hi16", v, hiExp[i]);
      rd(OFF_STATUS, v);            check("flag16", v, 8'(i));
    end
    $display("t_width16 done");
  endtask : t_width16

  // Capture spacing of 4*div cycles gives exactly four steps
  task automatic t_prescale();
    logic [7:0] a;
    logic [7:0] b;
    int div;
    for (int c = 0; c < 9; c++) begin
      div = (c == 8) ? 1 : (2 << c);
      wr(OFF_TIMER_CONTROL, (c == 8) ? 8'hc8 : 8'hc0 | 8'(c));
      rd(OFF_COUNT_LOW_BYTE, a);
      repeat (4 * div - 3) @(posedge clk);
      rd(OFF_COUNT_LOW_BYTE, b);
      check("ratio", b - a, 8'h04);
    end
    sleepMode <= 1'b1;
    rd(OFF_COUNT_LOW_BYTE, a);
    repeat (9) @(posedge clk);
    rd(OFF_COUNT_LOW_BYTE, b);    check("sleep", b - a, 8'h00);
    sleepMode <= 1'b0;
    // Low write restarts the 1:256 divide, first step 256 cycles later
    wr(OFF_TIMER_CONTROL, 8'hc7);
    wr(OFF_COUNT_LOW_BYTE, 8'h00);
    repeat (242) @(posedge clk);
    rd(OFF_COUNT_LOW_BYTE, a);    check("preclr", a, 8'h00);
    repeat (20) @(posedge clk);
    rd(OFF_COUNT_LOW_BYTE, b);    check("prestep", b, 8'h01);
    $display("t_prescale done");
  endtask : t_prescale

  task automatic t_counter();
    logic [7:0] v;
    wr(OFF_TIMER_CONTROL, 8'he8);
    wr(OFF_COUNT_LOW_BYTE, 8'h00);
    repeat (10) @(posedge clk);
    rd(OFF_COUNT_LOW_BYTE, v);    check("idle", v, 8'h00);
    pulses(4'h3);
    rd(OFF_COUNT_LOW_BYTE, v);    check("rise", v, 8'h02);
    wr(OFF_TIMER_CONTROL, 8'hf8);
    wr(OFF_COUNT_LOW_BYTE, 8'h00);
    pulses(4'h3);
    rd(OFF_COUNT_LOW_BYTE, v);    check("fall", v, 8'h02);
    $display("t_counter done");
  endtask : t_counter

  // ==========================================================
  // Verdict and main sequence
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  initial begin
    rst_n       = 1'b0;
    wbReq       = '0;
    sleepMode   = 1'b0;
    startReq    = 1'b0;
    numToggles  = 4'h0;
    num_errors  = 0;
    check_count = 0;
    cycles      = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_timer8();
    t_width16();
    t_prescale();
    t_counter();
    end_of_test();
  end
endmodule : eight_sixteen_bit_timer_tb
